// file: inc/irq_pkg.sv
// Constants, register map and source table for the interrupt latch, mask and sense block.
package irq_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam real LOWV_DEB_MS = 3.9;
	localparam real BTN_DEB_MS = 31.25;
	localparam real TEMP_DEB_MS = 3.9;
	localparam real OC_DEB_MS = 8.0;
	localparam real OV_DEB_MS = 0.122;
	localparam int LOWV_DEB_CYC = int'($ceil(LOWV_DEB_MS * CLK_HZ / 1000.0));
	localparam int BTN_DEB_CYC = int'($ceil(BTN_DEB_MS * CLK_HZ / 1000.0));
	localparam int TEMP_DEB_CYC = int'($ceil(TEMP_DEB_MS * CLK_HZ / 1000.0));
	localparam int OC_DEB_CYC = int'($ceil(OC_DEB_MS * CLK_HZ / 1000.0));
	localparam int OV_DEB_CYC = int'($ceil(OV_DEB_MS * CLK_HZ / 1000.0));
	localparam int NOW_CYC = 1;
	localparam int CNT_W = 24;
	localparam int NSRC = 20;
	localparam int NGRP = 4;
	localparam logic [6:0] I2C_ADDR = 7'h08;
	localparam logic [7:0] FLAG_ADDR [NGRP] = '{8'h05, 8'h08, 8'h0e, 8'h11};
	localparam logic [7:0] MASK_ADDR [NGRP] = '{8'h06, 8'h09, 8'h0f, 8'h12};
	localparam logic [7:0] LIVE_ADDR [NGRP] = '{8'h07, 8'h0a, 8'h10, 8'h13};
	localparam logic [7:0] FLAG_IMPL [NGRP] = '{8'h3f, 8'h1b, 8'hc5, 8'h3f};
	localparam logic [7:0] MASK_WR [NGRP] = '{8'h3f, 8'h7f, 8'hc5, 8'h3f};
	localparam logic [7:0] MASK_RST [NGRP] = '{8'h3f, 8'h7f, 8'hc5, 8'h3f};
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// Source order: button, low input, 4 temperatures, 4 bucks, boost, 6 linear, overvolt, fuse err, fuse done.
	localparam int SRC_BTN = 0;
	localparam int SRC_LOWV = 1;
	localparam int SRC_TEMP_LAST = 5;
	localparam int SRC_OC_LAST = 16;
	localparam int SRC_OV = 17;
	localparam int SRC_GRP [NSRC] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 3, 3, 3, 3, 3, 3, 2, 2, 2};
	localparam int SRC_BIT [NSRC] = '{0, 1, 2, 3, 4, 5, 0, 1, 3, 4, 0, 0, 1, 2, 3, 4, 5, 2, 7, 6};
	localparam logic [NSRC-1:0] RISE_TRIG = 20'hffffe;
	localparam logic [NSRC-1:0] FALL_TRIG = 20'h0003d;
	localparam int G0 = 0;
	localparam int G1 = 1;
	localparam int B_BTN = 0;
	localparam int B_LOWV = 1;
	localparam int B_BUCKA = 0;
	localparam int B_TEMPA = 2;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_REG = 9'h008,
		ST_REG_ACK = 9'h010,
		ST_WDATA = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA = 9'h080,
		ST_RDATA_ACK = 9'h100
	} i2c_state_t;
endpackage

// file: logic/deb_filter.sv
// Stability filter for one event source with separate rise and fall hold times.
`timescale 1ns/10ps
module deb_filter #(
	parameter int CNT_W = 24
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic raw,
	input wire logic [CNT_W-1:0] rise_cyc,
	input wire logic [CNT_W-1:0] fall_cyc,
	output logic filt,
	output logic rise_ev,
	output logic fall_ev
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] need;

	assign need = raw ? rise_cyc : fall_cyc;

	// Any bounce back to the filtered level restarts the count, so short pulses never pass.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			filt <= 1'b0;
			cnt_q <= '0;
			rise_ev <= 1'b0;
			fall_ev <= 1'b0;
		end else begin
			rise_ev <= 1'b0;
			fall_ev <= 1'b0;
			if (raw == filt) begin
				cnt_q <= '0;
			end else if (cnt_q + CNT_W'(1) >= need) begin
				filt <= raw;
				cnt_q <= '0;
				rise_ev <= raw;
				fall_ev <= !raw;
			end else begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end
	end

	a_deb_full_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$changed(filt) |-> $past(raw) == filt && $past(cnt_q) == $past(need) - CNT_W'(1))
		else $error("filtered level changed before the hold time ran out");
endmodule

// file: logic/pmic_irq_latch.sv
// Interrupt latch, mask and live sense registers behind a single byte I2C slave.
`timescale 1ns/10ps
module pmic_irq_latch #(
	parameter int LOWV_DEB_CYC = irq_pkg::LOWV_DEB_CYC,
	parameter int BTN_DEB_CYC = irq_pkg::BTN_DEB_CYC,
	parameter int BTN_EXT_CYC = irq_pkg::BTN_DEB_CYC,
	parameter int TEMP_DEB_CYC = irq_pkg::TEMP_DEB_CYC,
	parameter int OC_DEB_CYC = irq_pkg::OC_DEB_CYC,
	parameter int OV_DEB_CYC = irq_pkg::OV_DEB_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic irq_out_n,
	input wire logic button_pin,
	input wire logic [1:0] button_filter_ext,
	input wire logic low_input_det,
	input wire logic [3:0] temp_above,
	input wire logic [3:0] buck_over,
	input wire logic boost_over,
	input wire logic [5:0] linreg_over,
	input wire logic supply_ov,
	input wire logic fuse_error_det,
	input wire logic fuse_blow_done,
	input wire logic fuse_blow_busy,
	input wire logic test_strap,
	input wire logic fuse_supply
);
	localparam int CW = irq_pkg::CNT_W;
	localparam int NS = irq_pkg::NSRC;
	localparam int NG = irq_pkg::NGRP;
	localparam int G0 = irq_pkg::G0;
	localparam int G1 = irq_pkg::G1;
	localparam int B_BTN = irq_pkg::B_BTN;
	localparam int B_LOWV = irq_pkg::B_LOWV;
	localparam int B_BUCKA = irq_pkg::B_BUCKA;
	localparam int B_TEMPA = irq_pkg::B_TEMPA;

	logic [NS-1:0] raw;
	logic [NS-1:0] rise;
	logic [NS-1:0] fall;
	logic [NS-1:0] ev;
	logic [NG-1:0][7:0] set_vec;
	logic [NG-1:0][7:0] clr;
	logic [NG-1:0] mask_we;
	logic [NG-1:0][7:0] flags_q;
	logic [NG-1:0][7:0] mask_q;
	logic [NG-1:0][7:0] live;
	logic pend;
	logic irq_q;
	logic [7:0] rd_data;
	logic scl_q;
	logic scl_p;
	logic sda_q;
	logic sda_p;
	logic start;
	logic stop;
	logic scl_rise;
	logic scl_fall;
	irq_pkg::i2c_state_t st_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic [7:0] wdata_q;
	logic wr_stb_q;
	logic rd_q;
	logic oe_q;

	// Hold time for source i in the given direction; the button fall time grows with the extension field.
	function automatic logic [CW-1:0] deb_cyc(input int i, input logic fall_dir, input logic [1:0] ext);
		if (i == irq_pkg::SRC_BTN) begin
			deb_cyc = fall_dir ? CW'(BTN_DEB_CYC) + CW'(ext) * CW'(BTN_EXT_CYC) : CW'(BTN_DEB_CYC);
		end else if (i == irq_pkg::SRC_LOWV) begin
			deb_cyc = CW'(LOWV_DEB_CYC);
		end else if (i <= irq_pkg::SRC_TEMP_LAST) begin
			deb_cyc = CW'(TEMP_DEB_CYC);
		end else if (i <= irq_pkg::SRC_OC_LAST) begin
			deb_cyc = CW'(OC_DEB_CYC);
		end else if (i == irq_pkg::SRC_OV) begin
			deb_cyc = CW'(OV_DEB_CYC);
		end else begin
			deb_cyc = CW'(irq_pkg::NOW_CYC);
		end
	endfunction

	// A high low_input_det means the input is below threshold, so its rise is the voltage falling.
	assign raw = {fuse_blow_done, fuse_error_det, supply_ov, linreg_over, boost_over,
		buck_over, temp_above, low_input_det, button_pin};

	generate
		for (genvar i = 0; i < NS; i++) begin : g_src
			deb_filter #(
				.CNT_W(CW)
			) u_deb (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.raw(raw[i]),
				.rise_cyc(deb_cyc(i, 1'b0, button_filter_ext)),
				.fall_cyc(deb_cyc(i, 1'b1, button_filter_ext)),
				.filt(),
				.rise_ev(rise[i]),
				.fall_ev(fall[i])
			);
			assign ev[i] = (irq_pkg::RISE_TRIG[i] & rise[i]) | (irq_pkg::FALL_TRIG[i] & fall[i]);
		end
	endgenerate

	// Route each source event onto its flag bit.
	always_comb begin
		set_vec = '0;
		for (int i = 0; i < NS; i++) begin
			set_vec[irq_pkg::SRC_GRP[i]][irq_pkg::SRC_BIT[i]] =
				set_vec[irq_pkg::SRC_GRP[i]][irq_pkg::SRC_BIT[i]] | ev[i];
		end
	end

	always_comb begin
		for (int g = 0; g < NG; g++) begin
			clr[g] = (wr_stb_q && ptr_q == irq_pkg::FLAG_ADDR[g]) ? wdata_q : 8'h00;
			mask_we[g] = wr_stb_q && ptr_q == irq_pkg::MASK_ADDR[g];
		end
	end

	// A set in the same cycle as a clear wins, so no event is lost during the host's clear.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_q <= '0;
		end else begin
			for (int g = 0; g < NG; g++) begin
				flags_q[g] <= ((flags_q[g] & ~clr[g]) | set_vec[g]) & irq_pkg::FLAG_IMPL[g];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int g = 0; g < NG; g++) begin
				mask_q[g] <= irq_pkg::MASK_RST[g];
			end
		end else begin
			for (int g = 0; g < NG; g++) begin
				if (mask_we[g]) begin
					mask_q[g] <= wdata_q & irq_pkg::MASK_WR[g];
				end
			end
		end
	end

	// Masked flags still latch above; the mask only gates the pin.
	assign pend = |(flags_q & ~mask_q);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= pend;
		end
	end

	assign irq_out_n = ~irq_q;

	// Live bits are the raw levels, never stored.
	assign live[0] = {fuse_supply, test_strap, temp_above, low_input_det, button_pin};
	assign live[1] = {3'b000, buck_over[3], buck_over[2], buck_over[1], 1'b0, buck_over[0]};
	assign live[2] = {fuse_error_det, fuse_blow_busy, 3'b000, supply_ov, 1'b0, boost_over};
	assign live[3] = {2'b00, linreg_over};

	always_comb begin
		rd_data = irq_pkg::RD_UNMAPPED;
		for (int g = 0; g < NG; g++) begin
			if (ptr_q == irq_pkg::FLAG_ADDR[g]) begin
				rd_data = flags_q[g];
			end else if (ptr_q == irq_pkg::MASK_ADDR[g]) begin
				rd_data = mask_q[g];
			end else if (ptr_q == irq_pkg::LIVE_ADDR[g]) begin
				rd_data = live[g];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			scl_p <= 1'b1;
			sda_q <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_q <= scl;
			scl_p <= scl_q;
			sda_q <= sda_i;
			sda_p <= sda_q;
		end
	end

	assign start = scl_q && scl_p && sda_p && !sda_q;
	assign stop = scl_q && scl_p && !sda_p && sda_q;
	assign scl_rise = scl_q && !scl_p;
	assign scl_fall = !scl_q && scl_p;

	// Bits are taken on SCL rise and our drive changes on SCL fall, or is dropped at a start or stop, keeping SDA still while SCL is high inside a byte.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q <= irq_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			wdata_q <= 8'h00;
			wr_stb_q <= 1'b0;
			rd_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			wr_stb_q <= 1'b0;
			if (start) begin
				st_q <= irq_pkg::ST_ADDR;
				cnt_q <= 4'h0;
				oe_q <= 1'b0;
			end else if (stop) begin
				st_q <= irq_pkg::ST_IDLE;
				oe_q <= 1'b0;
			end else if (scl_rise) begin
				if (st_q == irq_pkg::ST_ADDR || st_q == irq_pkg::ST_REG || st_q == irq_pkg::ST_WDATA
					|| st_q == irq_pkg::ST_RDATA) begin
					sh_q <= {sh_q[6:0], sda_q};
					cnt_q <= cnt_q + 4'h1;
				end
			end else if (scl_fall) begin
				case (st_q)
					irq_pkg::ST_ADDR: begin
						if (cnt_q == irq_pkg::BITS_PER_BYTE) begin
							if (sh_q[7:1] == irq_pkg::I2C_ADDR) begin
								rd_q <= sh_q[0];
								oe_q <= 1'b1;
								st_q <= irq_pkg::ST_ADDR_ACK;
							end else begin
								st_q <= irq_pkg::ST_IDLE;
							end
						end
					end
					irq_pkg::ST_ADDR_ACK: begin
						cnt_q <= 4'h0;
						if (rd_q) begin
							oe_q <= ~rd_data[7];
							tx_q <= {rd_data[6:0], 1'b0};
							st_q <= irq_pkg::ST_RDATA;
						end else begin
							oe_q <= 1'b0;
							st_q <= irq_pkg::ST_REG;
						end
					end
					irq_pkg::ST_REG: begin
						if (cnt_q == irq_pkg::BITS_PER_BYTE) begin
							ptr_q <= sh_q;
							oe_q <= 1'b1;
							st_q <= irq_pkg::ST_REG_ACK;
						end
					end
					irq_pkg::ST_REG_ACK: begin
						oe_q <= 1'b0;
						cnt_q <= 4'h0;
						st_q <= irq_pkg::ST_WDATA;
					end
					irq_pkg::ST_WDATA: begin
						if (cnt_q == irq_pkg::BITS_PER_BYTE) begin
							wdata_q <= sh_q;
							wr_stb_q <= 1'b1;
							oe_q <= 1'b1;
							st_q <= irq_pkg::ST_WDATA_ACK;
						end
					end
					irq_pkg::ST_WDATA_ACK: begin
						// Only one data byte per transaction; later bytes go unanswered.
						oe_q <= 1'b0;
						st_q <= irq_pkg::ST_IDLE;
					end
					irq_pkg::ST_RDATA: begin
						if (cnt_q == irq_pkg::BITS_PER_BYTE) begin
							oe_q <= 1'b0;
							st_q <= irq_pkg::ST_RDATA_ACK;
						end else begin
							oe_q <= ~tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
					irq_pkg::ST_RDATA_ACK: begin
						st_q <= irq_pkg::ST_IDLE;
					end
					default: begin
						st_q <= irq_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe = oe_q;

	a_pin_follows_pend: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(rst_n) |-> irq_out_n == !$past(pend))
		else $error("interrupt pin does not follow pending flags");

	a_pin_held_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(flags_q[G1] & ~mask_q[G1]) != 8'h00 ##1 (flags_q[G1] & ~mask_q[G1]) != 8'h00 |-> !irq_out_n)
		else $error("pin released while a group one flag still pends");

	a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
		flags_q[G0][B_LOWV] && !clr[G0][B_LOWV] |=> flags_q[G0][B_LOWV])
		else $error("low input flag dropped without a clear");

	a_w1c_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clr[G0][B_TEMPA] && !set_vec[G0][B_TEMPA] |=> !flags_q[G0][B_TEMPA] ##1 irq_out_n || pend)
		else $error("written one failed to clear the flag or release the pin");

	a_set_beats_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		set_vec[G0][B_BTN] |=> flags_q[G0][B_BTN])
		else $error("event lost while its flag was being cleared");

	a_masked_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
		set_vec[G0][B_LOWV] && mask_q[G0][B_LOWV] && !pend && (set_vec & ~mask_q) == 32'h0 && !wr_stb_q
			|=> flags_q[G0][B_LOWV] && !pend)
		else $error("masked flag reached the interrupt pin");

	a_reset_masked: assert property (@(posedge sys_clk)
		!$past(rst_n) && rst_n |-> mask_q[G0] == irq_pkg::MASK_RST[G0] && mask_q[G1] == irq_pkg::MASK_RST[G1]
			&& irq_out_n)
		else $error("masks not all set after reset");

	a_unmask_fires: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(mask_q[G1][B_BUCKA]) && flags_q[G1][B_BUCKA] |=> !irq_out_n)
		else $error("unmasking a set flag did not assert the pin");

	a_zero_write_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_stb_q && ptr_q == irq_pkg::FLAG_ADDR[G0] && wdata_q == 8'h00 |=> flags_q[G0] == ($past(flags_q[G0])
			| $past(set_vec[G0])))
		else $error("zero write changed a flag");

	a_addr_ack: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q == irq_pkg::ST_ADDR && scl_fall && cnt_q == irq_pkg::BITS_PER_BYTE
			&& sh_q[7:1] == irq_pkg::I2C_ADDR |=> sda_oe && st_q == irq_pkg::ST_ADDR_ACK)
		else $error("own address not acknowledged");

	c_reg_write: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_stb_q);
	c_reg_read: cover property (@(posedge sys_clk) disable iff (!rst_n) st_q == irq_pkg::ST_RDATA_ACK);
	c_irq_assert: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(irq_out_n));
	c_set_and_clear: cover property (@(posedge sys_clk) disable iff (!rst_n) |(set_vec & clr));
endmodule

// file: verif/i2c_host_model.sv
// Behavioural I2C host that reaches the interrupt registers with single byte transfers.
`timescale 1ns/10ps
module i2c_host_model (
	input wire logic sys_clk,
	input wire logic sda_o,
	input wire logic sda_oe,
	output logic scl,
	output logic sda_wire
);
	logic host_pull;
	// The data line has a pull-up, so it reads high whenever nobody pulls it low.
	assign sda_wire = !(host_pull || (sda_oe && !sda_o));
	initial begin
		scl = 1'b1;
		host_pull = 1'b0;
	end
	// Six system cycles per phase stays well above the two that the slave needs to sample SCL.
	task automatic half();
		repeat (6) @(negedge sys_clk);
	endtask
	task automatic start();
		host_pull = 1'b0;
		half();
		scl = 1'b1;
		half();
		host_pull = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask
	task automatic stop();
		host_pull = 1'b1;
		half();
		scl = 1'b1;
		half();
		host_pull = 1'b0;
		half();
	endtask
	// Data changes one phase after SCL falls, so it never moves while SCL is high.
	task automatic clock_bit(input logic b, output logic s);
		host_pull = !b;
		half();
		scl = 1'b1;
		half();
		s = sda_wire;
		scl = 1'b0;
		half();
	endtask
	task automatic put_byte(input logic [7:0] d, output logic acked);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(d[i], s);
		end
		clock_bit(1'b1, s);
		acked = !s;
	endtask
	task automatic access(input logic [6:0] dev, input logic rd, input logic [7:0] reg_a, input logic [7:0] wd,
		output logic [7:0] q, output logic acked);
		logic s;
		q = 8'h00;
		start();
		put_byte({dev, 1'b0}, acked);
		if (acked) begin
			put_byte(reg_a, acked);
		end
		if (acked && !rd) begin
			put_byte(wd, acked);
		end
		if (acked && rd) begin
			start();
			put_byte({dev, 1'b1}, acked);
			for (int i = 7; i >= 0; i--) begin
				clock_bit(1'b1, q[i]);
			end
			clock_bit(1'b1, s);
		end
		stop();
	endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the interrupt latch, mask and live sense block.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	localparam int LOWV = 8;
	localparam int BTN = 12;
	localparam int EXT = 8;
	localparam int TEMP = 6;
	localparam int OC = 10;
	localparam int OV = 5;
	logic sys_clk, rst_n, scl, sda_wire, sda_o, sda_oe, irq_out_n, ok;
	logic button_pin, low_input_det, boost_over, supply_ov, fuse_error_det, fuse_blow_done;
	logic test_strap, fuse_supply, fuse_blow_busy;
	logic [5:0] linreg_over;
	logic [1:0] button_filter_ext;
	logic [3:0] temp_above, buck_over;
	logic [7:0] q;
	logic [31:0] seed;
	int n_fail, n_compared;
	pmic_irq_latch #(.LOWV_DEB_CYC(LOWV), .BTN_DEB_CYC(BTN), .BTN_EXT_CYC(EXT), .TEMP_DEB_CYC(TEMP),
		.OC_DEB_CYC(OC), .OV_DEB_CYC(OV)) pmic_irq_latch_i (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl),
		.sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe), .irq_out_n(irq_out_n), .button_pin(button_pin),
		.button_filter_ext(button_filter_ext), .low_input_det(low_input_det), .temp_above(temp_above),
		.buck_over(buck_over), .boost_over(boost_over), .linreg_over(linreg_over), .supply_ov(supply_ov),
		.fuse_error_det(fuse_error_det), .fuse_blow_done(fuse_blow_done), .fuse_blow_busy(fuse_blow_busy),
		.test_strap(test_strap), .fuse_supply(fuse_supply));
	i2c_host_model host_i (.sys_clk(sys_clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl(scl), .sda_wire(sda_wire));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] live1(input logic [3:0] b);
		return {3'b000, b[3], b[2], b[1], 1'b0, b[0]};
	endfunction
	function automatic logic [7:0] flag1(input logic [3:0] b);
		return {3'b000, b[3], b[2], 1'b0, b[1], b[0]};
	endfunction
	task automatic ticks(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_i.access(irq_pkg::I2C_ADDR, 1'b0, a, d, q, ok);
		`CHK(ok, 1'b1)
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host_i.access(irq_pkg::I2C_ADDR, 1'b1, a, 8'h00, q, ok);
		`CHK({ok, q}, {1'b1, e})
	endtask
	task automatic conclude();
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#(60000 * 50);
		n_fail++;
		conclude();
	end
	initial begin
		n_fail = 0;
		n_compared = 0;
		seed = 32'hf1ab;
		rst_n = 1'b0;
		button_pin = 1'b1;
		button_filter_ext = 2'b00;
		{low_input_det, temp_above, buck_over, boost_over, supply_ov} = '0;
		{fuse_error_det, fuse_blow_done, test_strap, fuse_supply} = '0;
		linreg_over = 6'h00;
		fuse_blow_busy = 1'b0;
		ticks(20);
		rst_n = 1'b1;
		ticks(2);
		`CHK(irq_out_n, 1'b1)
		rd_chk(8'h06, 8'h3f);
		rd_chk(8'h09, 8'h7f);
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h20, 8'h00);
		host_i.access(7'h09, 1'b1, 8'h05, 8'h00, q, ok);
		`CHK(ok, 1'b0)
		// Random source levels are read back live while every flag stays masked.
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			{test_strap, fuse_supply, temp_above, low_input_det, buck_over} = seed[10:0];
			rd_chk(8'h07, {fuse_supply, test_strap, temp_above, low_input_det, button_pin});
			rd_chk(8'h0a, live1(buck_over));
			`CHK(irq_out_n, 1'b1)
		end
		{temp_above, low_input_det, buck_over} = '0;
		wr(8'h0a, 8'hff);
		rd_chk(8'h0a, 8'h00);
		wr(8'h05, 8'hff);
		wr(8'h08, 8'hff);
		rd_chk(8'h05, 8'h00);
		low_input_det = 1'b1;
		ticks(LOWV - 2);
		low_input_det = 1'b0;
		ticks(20);
		rd_chk(8'h05, 8'h00);
		low_input_det = 1'b1;
		ticks(LOWV + 4);
		low_input_det = 1'b0;
		`CHK(irq_out_n, 1'b1)
		rd_chk(8'h05, 8'h02);
		wr(8'h06, 8'h3d);
		`CHK(irq_out_n, 1'b0)
		wr(8'h05, 8'h00);
		wr(8'h05, 8'hc1);
		rd_chk(8'h05, 8'h02);
		wr(8'h05, 8'h02);
		`CHK(irq_out_n, 1'b1)
		wr(8'h06, 8'h00);
		temp_above = 4'h5;
		ticks(TEMP + 4);
		rd_chk(8'h05, 8'h14);
		wr(8'h05, 8'h04);
		`CHK(irq_out_n, 1'b0)
		// The falling threshold lands while the clear of the other flag is on the bus.
		fork
			wr(8'h05, 8'h10);
			begin
				ticks(300);
				temp_above = 4'h4;
			end
		join
		`CHK(irq_out_n, 1'b0)
		rd_chk(8'h05, 8'h04);
		temp_above = 4'h0;
		ticks(TEMP + 4);
		wr(8'h05, 8'h14);
		`CHK(irq_out_n, 1'b1)
		button_filter_ext = 2'b01;
		button_pin = 1'b0;
		ticks(BTN + EXT - 2);
		`CHK(irq_out_n, 1'b1)
		ticks(6);
		`CHK(irq_out_n, 1'b0)
		button_pin = 1'b1;
		rd_chk(8'h05, 8'h01);
		wr(8'h05, 8'h01);
		wr(8'h09, 8'h00);
		seed = lfsr(seed);
		buck_over = seed[3:0] | 4'h1;
		ticks(OC - 2);
		buck_over = 4'h0;
		ticks(20);
		rd_chk(8'h08, 8'h00);
		buck_over = seed[3:0] | 4'h1;
		ticks(OC + 4);
		buck_over = 4'h0;
		`CHK(irq_out_n, 1'b0)
		rd_chk(8'h08, flag1(seed[3:0] | 4'h1));
		wr(8'h09, 8'h1b);
		`CHK(irq_out_n, 1'b1)
		rd_chk(8'h08, flag1(seed[3:0] | 4'h1));
		wr(8'h09, 8'h1a);
		`CHK(irq_out_n, 1'b0)
		wr(8'h08, 8'hff);
		wr(8'h0f, 8'h00);
		fuse_error_det = 1'b1;
		ticks(1);
		fuse_error_det = 1'b0;
		fuse_blow_done = 1'b1;
		ticks(1);
		fuse_blow_done = 1'b0;
		supply_ov = 1'b1;
		linreg_over = 6'h21;
		fuse_blow_busy = 1'b1;
		boost_over = 1'b1;
		ticks(OC + 4);
		rd_chk(8'h0e, 8'hc5);
		rd_chk(8'h10, 8'h45);
		rd_chk(8'h11, 8'h21);
		rd_chk(8'h13, 8'h21);
		wr(8'h0e, 8'hff);
		wr(8'h11, 8'hff);
		`CHK(irq_out_n, 1'b1)
		conclude();
	end
endmodule
